// File: logic/icw_pkg.sv
`default_nettype none
package icw_pkg;
   // Port addresses of the two command ports.
   localparam logic [15:0] ICW_PORT_EVEN = 16'h00c0;
   localparam logic [15:0] ICW_PORT_ODD  = 16'h00c2;
   // Initialization word 1 field positions.
   localparam int ICW_W1_SNGL_BIT = 1;
   localparam int ICW_W1_LTIM_BIT = 3;
   localparam int ICW_W1_MARK_BIT = 4;
   // Mode word field positions.
   localparam int ICW_W4_AUTO_BIT = 1;
   localparam int ICW_W4_MS_BIT   = 2;
   localparam int ICW_W4_BUF_BIT  = 3;
   localparam int ICW_W4_SFN_BIT  = 4;
   // Operation word decode positions.
   localparam int ICW_OP_SEL_BIT  = 3;
   // Reset values.
   localparam logic [7:0] ICW_MASK_RST = 8'hff;
   localparam logic [2:0] ICW_LOW_RST  = 3'h7;
   // Rotate/end commands in bits 7..5 of the rotate word.
   localparam logic [2:0] ICW_CMD_ROT_CLR  = 3'h0;
   localparam logic [2:0] ICW_CMD_EOI      = 3'h1;
   localparam logic [2:0] ICW_CMD_END_OF_SERVICE_SPECIFIC     = 3'h3;
   localparam logic [2:0] ICW_CMD_ROT_SET  = 3'h4;
   localparam logic [2:0] ICW_CMD_ROT_EOI  = 3'h5;
   localparam logic [2:0] ICW_CMD_SETPRI   = 3'h6;
   localparam logic [2:0] ICW_CMD_ROT_END_OF_SERVICE_SPECIFIC = 3'h7;
   // Host setup words.
   localparam logic [7:0] ICW_NBV_W1 = 8'h13;
   localparam logic [7:0] ICW_NBV_W2 = 8'h08;
   localparam logic [7:0] ICW_NBV_W4 = 8'h1d;
   localparam logic [7:0] ICW_BV_W1  = 8'h11;
   localparam logic [7:0] ICW_BV_W3M = 8'h01;
   localparam logic [7:0] ICW_BV_W3S = 8'h00;
   localparam logic [7:0] ICW_BV_W4S = 8'h19;
   localparam logic [7:0] ICW_SMM_ON  = 8'h68;
   localparam logic [7:0] ICW_SMM_OFF = 8'h48;
   localparam logic [7:0] ICW_RD_IRR  = 8'h0a;
   localparam logic [7:0] ICW_RD_ISR  = 8'h0b;
   // Host command codes on its register port.
   typedef enum logic [1:0] {ICW_SETUP_NBV, ICW_SETUP_MASTER,
      ICW_SETUP_SLAVE} icw_setup_t;
   // Host register offsets.
   localparam logic [3:0] ICW_H_CTRL   = 4'h0;
   localparam logic [3:0] ICW_H_STATUS = 4'h1;
   localparam logic [3:0] ICW_H_RAW    = 4'h2;
   localparam logic [3:0] ICW_H_RDATA  = 4'h3;
endpackage
`default_nettype wire

// File: logic/icw_if.sv
`timescale 1ns/1ps
`default_nettype none
interface icw_if;
   logic [15:0] addr;
   logic [7:0]  wdata;
   logic        wr;
   logic        rd;
   logic [7:0]  rdata;
   logic [7:0]  ir;
   logic        int_req;
   logic [2:0]  cas_code;
   logic        cas_valid;
   logic        int_acknowledge;
   logic [7:0]  vector;
   logic        vector_valid;
   modport dev (input addr, wdata, wr, rd, ir, cas_code, cas_valid,
      int_acknowledge, output rdata, int_req, vector, vector_valid);
   modport host (output addr, wdata, wr, rd, ir, cas_code, cas_valid,
      int_acknowledge, input rdata, int_req, vector, vector_valid);
endinterface
`default_nettype wire

// File: logic/icw_prio.sv
`timescale 1ns/1ps
`default_nettype none
// Picks the highest priority set bit of a vector, given the lowest level.
module icw_prio #(
   parameter int N = 8
) (
   input  wire logic [N-1:0]         req,
   input  wire logic [$clog2(N)-1:0] lowest,
   output logic                      hit,
   output logic [$clog2(N)-1:0]      level
);
   localparam int W = $clog2(N);
   initial begin
      if (N != (1 << W) || N < 2) $error("N must be a power of two");
   end
   // Scan upward from the lowest level; the last hit, the highest, stays.
   always_comb begin
      logic [W-1:0] idx;
      idx   = '0;
      hit   = 1'b0;
      level = '0;
      for (int k = N - 1; k >= 0; k--) begin
         idx = W'(lowest + W'(k) + W'(1));
         if (req[idx]) begin
            hit   = 1'b1;
            level = idx;
         end
      end
   end
endmodule
`default_nettype wire

// File: logic/icw_dev.sv
// The register offsets and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module icw_dev
   import icw_pkg::*;
#(
   parameter logic [15:0] BASE = icw_pkg::ICW_PORT_EVEN
) (
   input  wire logic clk,
   input  wire logic nrst,
   icw_if.dev        bus,
   output logic      ready,
   output logic      special_nested,
   output logic      buffered,
   output logic      master_sel
);
   import icw_pkg::*;
   typedef enum {ICW_S_WAIT1, ICW_S_WAIT2, ICW_S_WAIT3, ICW_S_WAIT4,
      ICW_S_RUN} icw_state_t;
   icw_state_t state_reg;
   logic [7:0] w1_reg, vec_reg, cas_reg;
   logic [7:0] pending_request_reg, in_service_reg, mask_reg, ir_d_reg;
   logic       auto_end_reg, rot_auto_reg, smm_reg, rd_isr_reg;
   logic [2:0] low_reg;
   logic [7:0] rdata_reg, vector_reg;
   logic       vvalid_reg;
   logic [2:0] level_field;
   logic       wr_even, wr_odd, is_init1, hit;
   logic [2:0] hi_level, svc_level;
   logic       svc_hit;
   logic [7:0] eligible;

   assign wr_even     = bus.wr && bus.addr == BASE;
   assign wr_odd      = bus.wr && bus.addr == BASE + 16'h0002;
   assign is_init1    = wr_even && bus.wdata[ICW_W1_MARK_BIT];
   assign level_field = bus.wdata[2:0];

   // Initialization sequence; a new first word always restarts it.
   always_ff @(posedge clk) begin
      if (!nrst) begin
         state_reg <= ICW_S_WAIT1;
         w1_reg    <= 8'h00;
         vec_reg   <= 8'h00;
         cas_reg   <= 8'h00;
      end else if (is_init1) begin
         state_reg <= ICW_S_WAIT2;
         w1_reg    <= bus.wdata;
      end else if (wr_odd) begin
         unique case (state_reg)
            ICW_S_WAIT2: begin
               vec_reg   <= {bus.wdata[7:3], 3'h0};
               // Single mode skips the cascade word.
               state_reg <= w1_reg[ICW_W1_SNGL_BIT] ? ICW_S_WAIT4
                                                    : ICW_S_WAIT3;
            end
            ICW_S_WAIT3: begin
               cas_reg   <= bus.wdata;
               state_reg <= ICW_S_WAIT4;
            end
            ICW_S_WAIT4: state_reg <= ICW_S_RUN;
            default: ;
         endcase
      end
   end

   // Mode word fields; nested mode holds until reprogrammed.
   always_ff @(posedge clk) begin
      if (!nrst) begin
         auto_end_reg   <= 1'b0;
         special_nested <= 1'b0;
         buffered       <= 1'b0;
         master_sel     <= 1'b0;
      end else if (wr_odd && state_reg == ICW_S_WAIT4) begin
         auto_end_reg   <= bus.wdata[ICW_W4_AUTO_BIT];
         buffered       <= bus.wdata[ICW_W4_BUF_BIT];
         master_sel     <= bus.wdata[ICW_W4_MS_BIT];
         special_nested <= bus.wdata[ICW_W4_SFN_BIT];
      end
   end

   assign ready = state_reg == ICW_S_RUN;

   // Mask, read select, special mask and rotation; only when running.
   always_ff @(posedge clk) begin
      if (!nrst) begin
         mask_reg     <= ICW_MASK_RST;
         rd_isr_reg   <= 1'b0;
         smm_reg      <= 1'b0;
         rot_auto_reg <= 1'b0;
         low_reg      <= ICW_LOW_RST;
      end else if (is_init1) begin
         // A restart drops back to fixed priority, level 0 highest.
         rot_auto_reg <= 1'b0;
         low_reg      <= ICW_LOW_RST;
         smm_reg      <= 1'b0;
         rd_isr_reg   <= 1'b0;
      end else if (ready) begin
         if (wr_odd)
            mask_reg <= bus.wdata;
         if (wr_even && bus.wdata[ICW_OP_SEL_BIT]) begin
            if (bus.wdata[1])
               rd_isr_reg <= bus.wdata[0];
            if (bus.wdata[6])
               smm_reg <= bus.wdata[5];
         end
         if (wr_even && !bus.wdata[ICW_OP_SEL_BIT]) begin
            unique case (bus.wdata[7:5])
               ICW_CMD_ROT_SET:  rot_auto_reg <= 1'b1;
               ICW_CMD_ROT_CLR:  rot_auto_reg <= 1'b0;
               ICW_CMD_ROT_EOI: begin
                  // Rotate on end also leaves automatic rotation on.
                  rot_auto_reg <= 1'b1;
                  if (svc_hit) low_reg <= svc_level;
               end
               ICW_CMD_EOI:      if (rot_auto_reg && svc_hit)
                                    low_reg <= svc_level;
               ICW_CMD_ROT_END_OF_SERVICE_SPECIFIC: low_reg <= level_field;
               ICW_CMD_SETPRI:   low_reg <= level_field;
               default: ;
            endcase
         end
      end
   end

   // Highest priority level in service, the target of a generic end.
   icw_prio #(.N(8)) u_svc (
      .req    (in_service_reg),
      .lowest (low_reg),
      .hit    (svc_hit),
      .level  (svc_level)
   );

   // Requests outside masks and above any level in service; under special mask, those not in service.
   always_comb begin
      eligible = pending_request_reg & ~mask_reg;
      if (!smm_reg && svc_hit)
         for (int k = 0; k < 8; k++)
            // Levels at or below the serviced one wait, unless special
            // nested lets the same level of a slave through again.
            if (3'(3'(k) - low_reg - 3'h1) >=
                3'(svc_level - low_reg - 3'h1) &&
                !(special_nested && 3'(k) == svc_level))
               eligible[k] = 1'b0;
      if (smm_reg)
         eligible = eligible & ~in_service_reg;
   end

   icw_prio #(.N(8)) u_req (
      .req    (eligible),
      .lowest (low_reg),
      .hit    (hit),
      .level  (hi_level)
   );

   // Request latch; edge or level by the first word's trigger bit.
   always_ff @(posedge clk) begin
      if (!nrst) begin
         ir_d_reg            <= 8'h00;
         pending_request_reg <= 8'h00;
      end else begin
         ir_d_reg <= bus.ir;
         if (!ready)
            pending_request_reg <= 8'h00;
         else if (w1_reg[ICW_W1_LTIM_BIT])
            pending_request_reg <= (pending_request_reg | (bus.ir & ~ir_d_reg))
               & ~((bus.int_acknowledge && hit) ? 8'(1) << hi_level : 8'h00);
         else
            pending_request_reg <= bus.ir;
      end
   end

   // In-service bits: set on acknowledge unless automatic end is on, cleared by end commands.
   always_ff @(posedge clk) begin
      if (!nrst || is_init1) begin
         in_service_reg <= 8'h00;
      end else if (ready) begin
         if (wr_even && !bus.wdata[ICW_OP_SEL_BIT]) begin
            unique case (bus.wdata[7:5])
               ICW_CMD_EOI, ICW_CMD_ROT_EOI:
                  if (svc_hit) in_service_reg[svc_level] <= 1'b0;
               ICW_CMD_END_OF_SERVICE_SPECIFIC, ICW_CMD_ROT_END_OF_SERVICE_SPECIFIC:
                  in_service_reg[level_field] <= 1'b0;
               default: ;
            endcase
         end
         // Last, so that a new acknowledge wins over an end word that
         // aims at the same level in the same cycle.
         if (bus.int_acknowledge && hit && !auto_end_reg)
            in_service_reg[hi_level] <= 1'b1;
      end
   end

   assign bus.int_req = ready && hit;

   // Vector answer: single mode always answers; a master answers itself unless the level is cascaded;
   // a slave answers only when the master's code matches its identity.
   always_ff @(posedge clk) begin
      if (!nrst) begin
         vector_reg <= 8'h00;
         vvalid_reg <= 1'b0;
      end else begin
         vvalid_reg <= 1'b0;
         if (bus.int_acknowledge && hit && ready) begin
            if (w1_reg[ICW_W1_SNGL_BIT] || (master_sel && !cas_reg[hi_level])
                || (!master_sel && bus.cas_valid
                    && bus.cas_code == cas_reg[2:0])) begin
               vector_reg <= vec_reg | {5'h00, hi_level};
               vvalid_reg <= 1'b1;
            end
         end
      end
   end
   assign bus.vector       = vector_reg;
   assign bus.vector_valid = vvalid_reg;

   // Status read: even port gives the selected register, odd the mask.
   always_ff @(posedge clk) begin
      if (!nrst)
         rdata_reg <= 8'h00;
      else if (bus.rd && bus.addr == BASE)
         rdata_reg <= rd_isr_reg ? in_service_reg : pending_request_reg;
      else if (bus.rd && bus.addr == BASE + 16'h0002)
         rdata_reg <= mask_reg;
      else
         rdata_reg <= 8'h00;
   end
   assign bus.rdata = rdata_reg;
endmodule
`default_nettype wire

// File: logic/icw_host.sv
`timescale 1ns/1ps
`default_nettype none
// Host end: plays setup sequences and raw port accesses onto the ports.
module icw_host
   import icw_pkg::*;
#(
   parameter logic [15:0] BASE = icw_pkg::ICW_PORT_EVEN
) (
   input  wire logic       clk,
   input  wire logic       nrst,
   icw_if.host             bus,
   input  wire logic [3:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic [7:0]      reg_rdata,
   output logic            host_int_enable,
   input  wire logic [7:0] ir_in,
   input  wire logic       ack_in,
   input  wire logic [2:0] cas_in,
   input  wire logic       cas_valid_in
);
   import icw_pkg::*;
   logic [2:0] step_reg;
   logic       busy_reg;
   icw_setup_t kind_reg;
   logic [7:0] vec_reg, last_rd_reg;
   logic [7:0] word;
   logic       odd;
   logic       rd_pend_reg;

   // Word list for each setup; the mask write blocks every input.
   always_comb begin
      word = 8'h00;
      odd  = 1'b1;
      unique case (step_reg)
         3'h0: begin
            odd  = 1'b0;
            word = kind_reg == ICW_SETUP_NBV ? ICW_NBV_W1 : ICW_BV_W1;
         end
         3'h1: word = vec_reg;
         3'h2: word = kind_reg == ICW_SETUP_MASTER ? ICW_BV_W3M : ICW_BV_W3S;
         3'h3: word = kind_reg == ICW_SETUP_SLAVE ? ICW_BV_W4S : ICW_NBV_W4;
         default: word = ICW_MASK_RST;
      endcase
   end

   // Sequencer: one write per cycle, interrupts held off meanwhile.
   always_ff @(posedge clk) begin
      if (!nrst) begin
         step_reg        <= 3'h0;
         busy_reg        <= 1'b0;
         kind_reg        <= ICW_SETUP_NBV;
         vec_reg         <= 8'h00;
         host_int_enable <= 1'b0;
      end else if (!busy_reg) begin
         if (reg_wr && reg_addr == ICW_H_CTRL && reg_wdata[7]) begin
            busy_reg        <= 1'b1;
            step_reg        <= 3'h0;
            kind_reg        <= icw_setup_t'(reg_wdata[1:0]);
            vec_reg         <= {reg_wdata[6:2], 3'h0};
            host_int_enable <= 1'b0;
         end else if (reg_wr && reg_addr == ICW_H_STATUS) begin
            host_int_enable <= reg_wdata[0];
         end
      end else begin
         // Single mode skips the cascade word.
         if (step_reg == 3'h1 && kind_reg == ICW_SETUP_NBV)
            step_reg <= 3'h3;
         else
            step_reg <= step_reg + 3'h1;
         if (step_reg == 3'h4)
            busy_reg <= 1'b0;
      end
   end

   // Port drive: setup words first, raw accesses when idle.
   always_ff @(posedge clk) begin
      if (!nrst) begin
         bus.addr  <= BASE;
         bus.wdata <= 8'h00;
         bus.wr    <= 1'b0;
         bus.rd    <= 1'b0;
      end else if (busy_reg) begin
         bus.addr  <= odd ? BASE + 16'h0002 : BASE;
         bus.wdata <= word;
         bus.wr    <= 1'b1;
         bus.rd    <= 1'b0;
      end else begin
         bus.addr  <= reg_wdata[0] ? BASE + 16'h0002 : BASE;
         bus.wdata <= reg_wdata;
         bus.wr    <= reg_wr && reg_addr == ICW_H_RAW && !reg_wdata[0];
         bus.rd    <= reg_wr && reg_addr == ICW_H_RDATA;
      end
   end

   // Raw write: address from bit 0 of the previous raw word is crude, so
   // the raw register instead sends data to the even port; a raw word with
   // bit 0 set is dropped, and the read-data offset reads the port that bit 0 of its word selects.
   always_ff @(posedge clk) begin
      if (!nrst) begin
         rd_pend_reg <= 1'b0;
         last_rd_reg <= 8'h00;
      end else begin
         rd_pend_reg <= bus.rd;
         if (rd_pend_reg)
            last_rd_reg <= bus.rdata;
      end
   end

   // Link side inputs passed to the device.
   assign bus.ir              = ir_in;
   assign bus.int_acknowledge = ack_in && host_int_enable;
   assign bus.cas_code        = cas_in;
   assign bus.cas_valid       = cas_valid_in;

   // Register read answer one cycle after the strobe.
   always_ff @(posedge clk) begin
      if (!nrst)
         reg_rdata <= 8'h00;
      else if (reg_rd && reg_addr == ICW_H_STATUS)
         reg_rdata <= {5'h00, bus.int_req, busy_reg, host_int_enable};
      else if (reg_rd && reg_addr == ICW_H_RDATA)
         reg_rdata <= last_rd_reg;
      else
         reg_rdata <= 8'h00;
   end
endmodule
`default_nettype wire

// File: tb/icw_chk.sv
`timescale 1ns/1ps
`default_nettype none
// Watches the host-to-device command bus beside the joined pair.
module icw_chk (
   input wire logic        clk,
   input wire logic        nrst,
   input wire logic [15:0] addr,
   input wire logic [7:0]  wdata,
   input wire logic        wr,
   input wire logic        rd,
   input wire logic [7:0]  rdata,
   input wire logic        int_req,
   input wire logic        int_acknowledge,
   input wire logic        vector_valid
);
   import icw_pkg::*;
   logic [1:0] step_reg;
   logic       done_reg;
   logic       single_reg;
   logic       known_reg;
   logic [7:0] mask_reg;
   logic       ev;
   logic       od;
   default clocking @(posedge clk);
   endclocking
   default disable iff (!nrst);
   // Decoded writes to the two command ports.
   assign ev = wr && addr == ICW_PORT_EVEN;
   assign od = wr && addr == ICW_PORT_ODD;
   // Mirror of the setup walk; the mask is trusted only once written after
   // setup, since a restart may or may not touch it.
   always_ff @(posedge clk) begin
      if (!nrst) begin
         step_reg   <= 2'h0;
         done_reg   <= 1'b0;
         single_reg <= 1'b0;
         known_reg  <= 1'b0;
         mask_reg   <= 8'h00;
      end else if (ev && wdata[ICW_W1_MARK_BIT]) begin
         step_reg   <= 2'h1;
         done_reg   <= 1'b0;
         single_reg <= wdata[ICW_W1_SNGL_BIT];
         known_reg  <= 1'b0;
      end else if (od) begin
         if (step_reg == 2'h1) begin
            step_reg <= single_reg ? 2'h3 : 2'h2;
         end else if (step_reg != 2'h0) begin
            step_reg <= step_reg + 2'h1;
            done_reg <= step_reg == 2'h3;
         end else if (done_reg) begin
            mask_reg  <= wdata;
            known_reg <= 1'b1;
         end
      end
   end
   a_rd_idle: assert property (
      !$past(rd) |-> rdata == 8'h00) else $error("read data not idle");
   a_req_wait: assert property (
      !done_reg |-> !int_req) else $error("request before setup done");
   a_masked_quiet: assert property (
      known_reg && mask_reg == 8'hff |-> !int_req)
      else $error("request while all masked");
   a_mask_read: assert property (
      rd && addr == ICW_PORT_ODD && known_reg |=> rdata == $past(mask_reg))
      else $error("mask read mismatch");
   a_odd_order: assert property (
      od |-> step_reg != 2'h0 || done_reg) else $error("odd write too early");
   a_strobe_excl: assert property (
      !(wr && rd)) else $error("read and write together");
   a_mask_follows: assert property (
      od && step_reg == 2'h3 |-> ##[1:4] (od && wdata == 8'hff))
      else $error("setup not closed by full mask");
   a_vec_quiet: assert property (
      !$past(int_acknowledge) |-> !vector_valid)
      else $error("vector without acknowledge");
endmodule
`default_nettype wire

// File: tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import icw_pkg::*;
   logic       clk;
   logic       nrst;
   logic [3:0] reg_addr;
   logic [7:0] reg_wdata;
   logic       reg_wr;
   logic       reg_rd;
   logic [7:0] reg_rdata;
   logic       host_int_enable;
   logic [7:0] ir_in;
   logic       ack_in;
   logic [2:0] cas_in;
   logic       cas_valid_in;
   logic       rdy1, sn1, buf1, ms1;
   logic       rdy2, sn2, buf2, ms2;
   int         errors = 0;
   int         checks = 0;
   int         cycles = 0;
   icw_if bif ();
   icw_if bif2 ();
   icw_host icw_host_i (.clk(clk), .nrst(nrst), .bus(bif.host),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .host_int_enable(host_int_enable), .ir_in(ir_in), .ack_in(ack_in),
      .cas_in(cas_in), .cas_valid_in(cas_valid_in));
   icw_dev icw_dev_i (.clk(clk), .nrst(nrst), .bus(bif.dev), .ready(rdy1),
      .special_nested(sn1), .buffered(buf1), .master_sel(ms1));
   // Second device driven straight from the bench, since the host end can
   // never clear the mask it sets.
   icw_dev icw_dev_i2 (.clk(clk), .nrst(nrst), .bus(bif2.dev),
      .ready(rdy2), .special_nested(sn2), .buffered(buf2),
      .master_sel(ms2));
   icw_chk icw_chk_i (.clk(clk), .nrst(nrst), .addr(bif.addr),
      .wdata(bif.wdata), .wr(bif.wr), .rd(bif.rd), .rdata(bif.rdata),
      .int_req(bif.int_req), .int_acknowledge(bif.int_acknowledge),
      .vector_valid(bif.vector_valid));

   task automatic conclude();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [7:0] seen,
      input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // Host register port; the trailing delay lets the edge's updates land.
   task automatic rw(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      #1;
   endtask
   task automatic rr(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task automatic idle();
      logic [7:0] s;
      for (int i = 0; i < 40; i++) begin
         rr(ICW_H_STATUS, s);
         if (!s[1]) break;
      end
      chk("setup busy", {7'h0, s[1]}, 8'h00);
   endtask
   // Port read through the host, then fetch the latched byte.
   task automatic hread(input logic odd, output logic [7:0] d);
      rw(ICW_H_RDATA, {7'h0, odd});
      repeat (4) @(posedge clk);
      rr(ICW_H_RDATA, d);
   endtask
   // Direct port cycles on the second device.
   task automatic pw(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk);
      bif2.addr  <= a;
      bif2.wdata <= d;
      bif2.wr    <= 1'b1;
      @(posedge clk);
      bif2.wr <= 1'b0;
      #1;
   endtask
   task automatic we(input logic [7:0] d);
      pw(ICW_PORT_EVEN, d);
   endtask
   task automatic wo(input logic [7:0] d);
      pw(ICW_PORT_ODD, d);
   endtask
   task automatic pr(input logic [15:0] a, output logic [7:0] d);
      @(posedge clk);
      bif2.addr <= a;
      bif2.rd   <= 1'b1;
      @(posedge clk);
      bif2.rd <= 1'b0;
      #1 d = bif2.rdata;
   endtask
   task automatic ack(output logic v, output logic [7:0] vec);
      @(posedge clk);
      bif2.int_acknowledge <= 1'b1;
      @(posedge clk);
      bif2.int_acknowledge <= 1'b0;
      #1 v = bif2.vector_valid;
      vec = bif2.vector;
   endtask

   // Host setups; a second order while busy must be dropped.
   task automatic t_host();
      logic [7:0] d;
      ir_in <= 8'h01;
      rw(ICW_H_CTRL, 8'h84);
      idle();
      hread(1'b1, d);
      chk("nbv mask", d, 8'hff);
      chk("nbv req", {7'h0, bif.int_req}, 8'h00);
      chk("nbv mode", {4'h0, rdy1, sn1, buf1, ms1}, 8'h0f);
      rw(ICW_H_CTRL, 8'h85);
      idle();
      chk("master", {4'h0, rdy1, sn1, buf1, ms1}, 8'h0f);
      chk("master buf", {7'h0, buf1}, 8'h01);
      rw(ICW_H_STATUS, 8'h01);
      rr(ICW_H_STATUS, d);
      chk("enable", {7'h0, d[0]}, 8'h01);
      chk("enable pin", {7'h0, host_int_enable}, 8'h01);
      rw(ICW_H_CTRL, 8'h86);
      rw(ICW_H_CTRL, 8'h84);
      idle();
      chk("slave", {5'h0, rdy1, buf1, ms1}, 8'h06);
      chk("int off", {7'h0, host_int_enable}, 8'h00);
      // A raw even write selects the request register, then read it.
      rw(ICW_H_RAW, ICW_RD_IRR);
      hread(1'b0, d);
      chk("raw irr", d, 8'h01);
      $display("test host done");
   endtask
   // Short and cascaded setups, restart, and slave identity match.
   task automatic t_init();
      logic       v;
      logic [7:0] d;
      we(8'h13);
      wo(8'h08);
      chk("early", {7'h0, rdy2}, 8'h00);
      wo(8'h1d);
      chk("mode", {4'h0, rdy2, sn2, buf2, ms2}, 8'h0f);
      we(8'h11);
      chk("restart", {7'h0, rdy2}, 8'h00);
      wo(8'h08);
      wo(8'h1d);
      chk("cascade", {7'h0, rdy2}, 8'h00);
      wo(8'h19);
      chk("slave", {5'h0, rdy2, buf2, ms2}, 8'h06);
      wo(8'h00);
      @(posedge clk);
      bif2.ir        <= 8'h01;
      bif2.cas_code  <= 3'h5;
      bif2.cas_valid <= 1'b1;
      ack(v, d);
      chk("id match", {v, d[6:0]}, 8'h88);
      @(posedge clk);
      bif2.cas_code <= 3'h4;
      ack(v, d);
      chk("id miss", {7'h0, v}, 8'h00);
      $display("test init done");
   endtask
   // End commands, rotation, selects and masks in service.
   task automatic t_serve();
      logic       v;
      logic [7:0] d;
      we(8'h13);
      wo(8'h08);
      wo(8'h1d);
      wo(8'h00);
      we(ICW_RD_ISR);
      @(posedge clk);
      bif2.ir <= 8'h06;
      ack(v, d);
      chk("first", d, 8'h09);
      pr(ICW_PORT_EVEN, d);
      chk("isr set", d, 8'h02);
      we(8'h20);
      pr(ICW_PORT_EVEN, d);
      chk("eoi", d, 8'h00);
      ack(v, d);
      chk("again", d, 8'h09);
      we(8'h61);
      pr(ICW_PORT_EVEN, d);
      chk("end_of_service_specific", d, 8'h00);
      we(8'hc1);
      ack(v, d);
      chk("bottom", d, 8'h0a);
      we(8'he2);
      pr(ICW_PORT_EVEN, d);
      chk("rot end_of_service_specific", d, 8'h00);
      we(8'ha0);
      ack(v, d);
      chk("after rot", d, 8'h09);
      we(8'h20);
      ack(v, d);
      chk("auto rot", d, 8'h0a);
      we(8'h20);
      wo(8'h06);
      chk("masked", {7'h0, bif2.int_req}, 8'h00);
      pr(ICW_PORT_ODD, d);
      chk("mask rd", d, 8'h06);
      we(ICW_RD_IRR);
      pr(ICW_PORT_EVEN, d);
      chk("irr rd", d, 8'h06);
      // A word to some other card's port must leave this one alone.
      pw(ICW_PORT_EVEN + 16'h0040, ICW_NBV_W1);
      chk("foreign port", {7'h0, rdy2}, 8'h01);
      $display("test serve done");
   endtask
   // Special mask, rotation off, then edge trigger with automatic end.
   task automatic t_modes();
      logic       v;
      logic [7:0] d;
      wo(8'h00);
      ack(v, d);
      wo(8'h02);
      chk("nested hold", {7'h0, bif2.int_req}, 8'h00);
      we(ICW_SMM_ON);
      chk("smm on", {7'h0, bif2.int_req}, 8'h01);
      we(ICW_SMM_OFF);
      chk("smm off", {7'h0, bif2.int_req}, 8'h00);
      we(8'h00);
      we(8'h20);
      wo(8'h00);
      ack(v, d);
      chk("no rotate", d, 8'h09);
      we(8'h1b);
      wo(8'h10);
      wo(8'h1f);
      wo(8'h00);
      chk("no edge", {7'h0, bif2.int_req}, 8'h00);
      @(posedge clk);
      bif2.ir <= 8'h00;
      @(posedge clk);
      bif2.ir <= 8'h08;
      ack(v, d);
      chk("edge vec", {v, d[6:0]}, 8'h93);
      pr(ICW_PORT_EVEN, d);
      chk("edge once", d, 8'h00);
      we(ICW_RD_ISR);
      pr(ICW_PORT_EVEN, d);
      chk("auto end", d, 8'h00);
      $display("test modes done");
   endtask

   // Free-running 200 MHz clock.
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // A run far past the expected length is cut short.
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         errors++;
         conclude();
      end
   end
   // Reset, then the scenarios in turn.
   initial begin
      nrst                 <= 1'b0;
      reg_addr             <= 4'h0;
      reg_wdata            <= 8'h00;
      reg_wr               <= 1'b0;
      reg_rd               <= 1'b0;
      ir_in                <= 8'h00;
      ack_in               <= 1'b0;
      cas_in               <= 3'h0;
      cas_valid_in         <= 1'b0;
      bif2.addr            <= 16'h0000;
      bif2.wdata           <= 8'h00;
      bif2.wr              <= 1'b0;
      bif2.rd              <= 1'b0;
      bif2.ir              <= 8'h00;
      bif2.cas_code        <= 3'h0;
      bif2.cas_valid       <= 1'b0;
      bif2.int_acknowledge <= 1'b0;
      repeat (6) @(posedge clk);
      nrst <= 1'b1;
      t_host();
      t_init();
      t_serve();
      t_modes();
      conclude();
   end
endmodule
`default_nettype wire
